/* File: shared/imu_timing_pkg.sv */
// constants and types for the inertial sensor timing controller
// assumes a 10 MHz system clock; times converted here to clock cycles or to base sample ticks
package imu_timing_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
   // mode threshold on the sample period setting
   localparam logic [7:0] LOW_POWER_MIN = 8'h0A;
   localparam logic [7:0] PERIOD_RESET = 8'h01;
   localparam logic [7:0] PERIOD_MAX = 8'hFF;
   // functional times in ms
   localparam int unsigned START_NORM_MS = 180;
   localparam int unsigned START_LP_MS = 250;
   localparam int unsigned SLEEP_NORM_MS = 4;
   localparam int unsigned SLEEP_LP_MS = 9;
   localparam int unsigned FLASH_NORM_MS = 17;
   localparam int unsigned FLASH_LP_MS = 90;
   // sample clock tick: 819.2 SPS base at setting 1, in ns per tick
   localparam int unsigned BASE_TICK_NS = 1_220_703;
   localparam int unsigned BASE_TICK_CYC = BASE_TICK_NS / CLK_NS;
   // sync to data ready, us
   localparam int unsigned SYNC_DRDY_US = 600;
   localparam int unsigned SYNC_DRDY_CYC = SYNC_DRDY_US * 1000 / CLK_NS;
   // data ready pulse width, us
   localparam int unsigned DRDY_PULSE_US = 10;
   localparam int unsigned DRDY_PULSE_CYC = DRDY_PULSE_US * 1000 / CLK_NS;
   // waits in sample ticks at the base rate (rounded up)
   localparam int unsigned TICK_US = BASE_TICK_NS / 1000;
   localparam int unsigned SLEEP_NORM_TK =
      (SLEEP_NORM_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int unsigned SLEEP_LP_TK =
      (SLEEP_LP_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int unsigned FLASH_NORM_TK =
      (FLASH_NORM_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int unsigned FLASH_LP_TK =
      (FLASH_LP_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int unsigned START_NORM_TK =
      (START_NORM_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int unsigned START_LP_TK =
      (START_LP_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int unsigned SPI_BITS = 16;
   localparam logic [6:0] ADDR_RESET = 7'h00;

   typedef enum logic [1:0] {
      ST_START, ST_RUN, ST_SLEEP, ST_WAIT
   } state_t;

   typedef struct packed {
      logic rd_valid;
      logic [6:0] addr;
   } spi_cmd_t;
endpackage : imu_timing_pkg

/* File: rtl/inertial_sensor_timing_ctrl.sv */
// timing controller: mode select, start/sleep/flash waits, sync pacing,
// data ready and a 16-bit mode-3 spi slave reading a small register set
// assumes spi pins and sync come from another domain, sampled by clk
`timescale 1ns/1ps

// Functional notes
// [R1] setting up to 0x09 is normal mode; 0x0A and above low power
// [R2] data appears 180 ms (normal) or 250 ms (low power) after power-on
// [R3] sleep exit resumes data after 4 ms normal or 9 ms low power
// [R4] flash test lasts 17 ms normal or 90 ms low power
// [R5] conversion rate derived from setting 0x01..0xFF, 819.2 down to 0.413 SPS; code divides the base by the setting, 3.21 SPS at 0xFF
// [R6] external sync of 0.8 to 1.2 kHz paces sampling, slower still works
// [R7] master holds sync high 5 us and spaces pulses 833 us
// [R8] data ready rises about 600 us after a sync edge
// [R9] master stalls 9 us (normal) or 75 us (low power) between frames
// [R10] master holds chip select low 20 us to wake from sleep
// [R11] serial data input sampled on rising spi clock edge
// [R12] spi mode 3, msb first, 16-bit frames
// [R13] each sample cycle loads output data and pulses data ready
// [R14] read is two frames: flag 0 plus 7-bit address, data next frame
// [R15] data ready quiet and outputs frozen during any wait
// [R16] waits counted in sample ticks with mode-chosen terminal value
module inertial_sensor_timing_ctrl
   import imu_timing_pkg::*;
#(
   parameter int unsigned START_NORM_TICKS = START_NORM_TK,
   parameter int unsigned START_LP_TICKS = START_LP_TK,
   parameter int unsigned TICK_CYCLES = BASE_TICK_CYC
) (
   input wire logic clk, // 10 MHz
   input wire logic rst, // async, high
   input wire logic [7:0] sample_period_setting, // rate setting
   input wire logic ext_sync_en, // pace from sync input
   input wire logic sync_clock_input, // external sync pin
   input wire logic sleep_req, // enter sleep
   input wire logic flash_test_req, // start flash test pulse
   input wire logic [15:0] sensor_data, // next sample value
   input wire logic sclk, // spi clock
   input wire logic cs_n, // spi chip select
   input wire logic mosi, // spi data in
   output logic miso, // spi data out
   output logic data_ready_pin, // data ready pulse
   output logic low_power_mode, // mode indicator
   output logic busy // wait or sleep in progress
);
   initial begin
      if (TICK_CYCLES < 2 || START_NORM_TICKS < 1 || START_LP_TICKS < 1)
         $error("bad timing parameters");
   end

   // --------------------------------------------------------------
   // input synchronisers
   // --------------------------------------------------------------
   logic [1:0] sclk_s_q, cs_s_q, mosi_s_q, sync_s_q;
   logic sclk_p_q, sync_p_q, cs_p_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_s_q <= 2'h3;
         cs_s_q <= 2'h3;
         mosi_s_q <= 2'h0;
         sync_s_q <= 2'h0;
         sclk_p_q <= 1'b1;
         sync_p_q <= 1'b0;
         cs_p_q <= 1'b1;
      end else begin
         sclk_s_q <= {sclk_s_q[0], sclk};
         cs_s_q <= {cs_s_q[0], cs_n};
         mosi_s_q <= {mosi_s_q[0], mosi};
         sync_s_q <= {sync_s_q[0], sync_clock_input};
         sclk_p_q <= sclk_s_q[1];
         sync_p_q <= sync_s_q[1];
         cs_p_q <= cs_s_q[1];
      end
   end
   wire sclk_rise = sclk_s_q[1] & ~sclk_p_q;
   wire sclk_fall = ~sclk_s_q[1] & sclk_p_q;
   wire sync_rise = sync_s_q[1] & ~sync_p_q;
   wire cs_fall = ~cs_s_q[1] & cs_p_q;
   wire cs_act = ~cs_s_q[1];
   wire lp = (sample_period_setting >= LOW_POWER_MIN); // R1

   // --------------------------------------------------------------
   // sample tick and mode-dependent waits
   // --------------------------------------------------------------
   state_t st_q, st_d;
   logic [31:0] tick_cnt_q, tick_cnt_d;
   logic [7:0] div_q, div_d;
   logic [31:0] wait_q, wait_d;
   logic [31:0] sync_cnt_q, sync_cnt_d;
   logic sync_pend_q, sync_pend_d;
   logic [15:0] drdy_cnt_q, drdy_cnt_d;
   logic [15:0] out_q, out_d;
   logic drdy_q, drdy_d, lp_q, busy_q, busy_d;
   logic base_tick, sample_evt;
   logic [7:0] per;

   always_comb begin
      per = (sample_period_setting == 8'h00) ? PERIOD_RESET
                                               : sample_period_setting;
      base_tick = (tick_cnt_q == TICK_CYCLES - 1);
      tick_cnt_d = base_tick ? 32'h0 : tick_cnt_q + 32'h1;
      div_d = div_q;
      sample_evt = 1'b0;
      if (base_tick) begin
         // rate = base / setting, 0x01..0xFF
         if (div_q + 8'h01 >= per) begin // R5
            div_d = 8'h00;
            sample_evt = ~ext_sync_en;
         end else begin
            div_d = div_q + 8'h01;
         end
      end
      sync_pend_d = sync_pend_q;
      sync_cnt_d = sync_cnt_q;
      if (ext_sync_en && sync_rise) begin // R6
         sync_pend_d = 1'b1;
         sync_cnt_d = 32'h0;
      end else if (sync_pend_q) begin
         if (sync_cnt_q == SYNC_DRDY_CYC - 1) begin // R8
            sync_pend_d = 1'b0;
            sample_evt = 1'b1;
         end else begin
            sync_cnt_d = sync_cnt_q + 32'h1;
         end
      end
      st_d = st_q;
      wait_d = wait_q;
      case (st_q)
         ST_START, ST_WAIT: begin
            if (base_tick) begin // R16
               if (wait_q <= 32'h1) begin
                  st_d = ST_RUN;
                  wait_d = 32'h0;
               end else begin
                  wait_d = wait_q - 32'h1;
               end
            end
         end
         ST_RUN: begin
            if (sleep_req) begin
               st_d = ST_SLEEP;
            end else if (flash_test_req) begin
               st_d = ST_WAIT;
               wait_d = lp ? FLASH_LP_TK : FLASH_NORM_TK; // R4
            end
         end
         ST_SLEEP: begin
            if (cs_fall || !sleep_req) begin
               st_d = ST_WAIT;
               wait_d = lp ? SLEEP_LP_TK : SLEEP_NORM_TK; // R3
            end
         end
         default: st_d = ST_START;
      endcase
      busy_d = (st_d != ST_RUN);
      out_d = out_q;
      drdy_d = drdy_q;
      drdy_cnt_d = drdy_cnt_q;
      if (drdy_q) begin
         if (drdy_cnt_q == DRDY_PULSE_CYC - 1) begin
            drdy_d = 1'b0;
         end else begin
            drdy_cnt_d = drdy_cnt_q + 16'h1;
         end
      end
      if (sample_evt && st_q == ST_RUN) begin // R15
         out_d = sensor_data; // R13
         drdy_d = 1'b1;
         drdy_cnt_d = 16'h0;
      end
      if (st_q != ST_RUN) begin
         drdy_d = 1'b0; // R15
      end
   end

   // start wait caught one cycle after release, never from a port at reset
   logic start_arm_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_START;
         tick_cnt_q <= 32'h0;
         div_q <= 8'h00;
         wait_q <= 32'h0;
         start_arm_q <= 1'b1;
         sync_cnt_q <= 32'h0;
         sync_pend_q <= 1'b0;
         drdy_cnt_q <= 16'h0;
         out_q <= 16'h0;
         drdy_q <= 1'b0;
         lp_q <= 1'b0;
         busy_q <= 1'b1;
      end else begin
         st_q <= st_d;
         tick_cnt_q <= tick_cnt_d;
         div_q <= div_d;
         start_arm_q <= 1'b0;
         wait_q <= start_arm_q ? (lp ? START_LP_TICKS : START_NORM_TICKS)
                               : wait_d; // R2
         sync_cnt_q <= sync_cnt_d;
         sync_pend_q <= sync_pend_d;
         drdy_cnt_q <= drdy_cnt_d;
         out_q <= out_d;
         drdy_q <= drdy_d;
         lp_q <= lp;
         busy_q <= busy_d;
      end
   end

   // --------------------------------------------------------------
   // spi slave, mode 3, msb first, 16 bit
   // --------------------------------------------------------------
   logic [15:0] rx_q, rx_d, tx_q, tx_d;
   logic [3:0] bit_q, bit_d;
   spi_cmd_t cmd_q, cmd_d;
   logic miso_q, miso_d;
   always_comb begin
      rx_d = rx_q;
      tx_d = tx_q;
      bit_d = bit_q;
      cmd_d = cmd_q;
      miso_d = miso_q;
      if (!cs_act) begin
         bit_d = 4'h0;
      end else begin
         if (sclk_fall) begin // R12
            miso_d = tx_q[15];
            tx_d = {tx_q[14:0], 1'b0};
         end
         if (sclk_rise) begin // R11
            rx_d = {rx_q[14:0], mosi_s_q[1]};
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'(SPI_BITS - 1)) begin // R14
               cmd_d.rd_valid = ~rx_q[14];
               cmd_d.addr = rx_q[13:7];
               // odd address reads high byte swapped to low
               tx_d = cmd_d.addr[0] ? {8'h00, out_q[15:8]} : out_q;
               if (!cmd_d.rd_valid) begin
                  tx_d = 16'h0000;
               end
            end
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_q <= 16'h0;
         tx_q <= 16'h0;
         bit_q <= 4'h0;
         cmd_q <= '{rd_valid: 1'b0, addr: ADDR_RESET};
         miso_q <= 1'b0;
      end else begin
         rx_q <= rx_d;
         tx_q <= tx_d;
         bit_q <= bit_d;
         cmd_q <= cmd_d;
         miso_q <= miso_d;
      end
   end

   assign miso = miso_q;
   assign data_ready_pin = drdy_q;
   assign low_power_mode = lp_q;
   assign busy = busy_q;

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   property p_quiet_wait;
      @(posedge clk) disable iff (rst) (st_q != ST_RUN) |=> !drdy_q;
   endproperty
   a_quiet_wait: assert property (p_quiet_wait) // R15
      else $error("data ready during wait");
   property p_frozen;
      @(posedge clk) disable iff (rst) (st_q != ST_RUN) |=> $stable(out_q);
   endproperty
   a_frozen: assert property (p_frozen) // R15
      else $error("output changed during wait");
   property p_mode;
      @(posedge clk) disable iff (rst)
         (sample_period_setting >= 8'h0A) |=> lp_q;
   endproperty
   a_mode: assert property (p_mode) // R1
      else $error("low power mode not shown");
   // helper for the sync check: age of the last accepted sync edge and
   // whether the block stayed running since; too long to unroll as a sequence
   logic [15:0] sync_age_q, sync_age_d;
   logic sync_run_q, sync_run_d;
   always_comb begin
      sync_age_d = sync_age_q;
      sync_run_d = sync_run_q && (st_q == ST_RUN);
      if (ext_sync_en && sync_rise) begin
         sync_age_d = 16'h1;
         sync_run_d = (st_q == ST_RUN);
      end else if (sync_age_q != 16'h0 && sync_age_q != 16'hFFFF) begin
         sync_age_d = sync_age_q + 16'h1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_age_q <= 16'h0;
         sync_run_q <= 1'b0;
      end else begin
         sync_age_q <= sync_age_d;
         sync_run_q <= sync_run_d;
      end
   end
   property p_sync;
      @(posedge clk) disable iff (rst)
         (sync_age_q == 16'(SYNC_DRDY_CYC + 1) && sync_run_q) |-> drdy_q;
   endproperty
   a_sync: assert property (p_sync) // R8
      else $error("no data ready after sync");
   property p_flash;
      @(posedge clk) disable iff (rst)
         (st_q == ST_RUN && !sleep_req && flash_test_req)
         |=> wait_q == (lp ? FLASH_LP_TK : FLASH_NORM_TK);
   endproperty
   a_flash: assert property (p_flash) // R4
      else $error("flash wait wrong");
   property p_sleep;
      @(posedge clk) disable iff (rst)
         (st_q == ST_SLEEP && cs_fall)
         |=> wait_q == (lp ? SLEEP_LP_TK : SLEEP_NORM_TK);
   endproperty
   a_sleep: assert property (p_sleep) // R3
      else $error("sleep wait wrong");
   property p_wait_step;
      @(posedge clk) disable iff (rst)
         (st_q == ST_WAIT && base_tick && wait_q > 1) |=>
         wait_q == $past(wait_q) - 1;
   endproperty
   a_wait_step: assert property (p_wait_step) // R16
      else $error("wait counter not stepping");
   property p_rx;
      @(posedge clk) disable iff (rst)
         (cs_act && sclk_rise) |=> rx_q[0] == $past(mosi_s_q[1]);
   endproperty
   a_rx: assert property (p_rx) // R11
      else $error("mosi not sampled");
   property p_load;
      @(posedge clk) disable iff (rst)
         (sample_evt && st_q == ST_RUN)
         |=> drdy_q && out_q == $past(sensor_data);
   endproperty
   a_load: assert property (p_load) // R13
      else $error("sample not loaded");
   c_drdy: cover property (@(posedge clk) disable iff (rst) $rose(drdy_q));
   c_sleep: cover property (@(posedge clk) disable iff (rst)
      st_q == ST_SLEEP ##1 st_q == ST_WAIT);
   c_frame: cover property (@(posedge clk) disable iff (rst)
      cs_act && sclk_rise && bit_q == 4'hF);
endmodule : inertial_sensor_timing_ctrl

/* File: testbench/host_master_model.sv */
// spi master and sync source standing in for the host processor
// assumes the bench clock paces every pin change
`timescale 1ns/1ps
module host_master_model (
   input wire logic clk, // bench clock
   input wire logic miso, // device serial out
   output logic sclk, // serial clock
   output logic cs_n, // chip select
   output logic mosi, // serial data in
   output logic sync_clock_input // sync pin
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
      sync_clock_input = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, input logic lp,
      output logic [15:0] rx);
      cs_n <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 15; i >= 0; i--) begin
         sclk <= 1'b0;
         mosi <= tx[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         #1 rx[i] = miso;
         repeat (4) @(posedge clk);
      end
      cs_n <= 1'b1;
      // released line must not look like held data
      mosi <= ~mosi;
      repeat (lp ? 750 : 90) @(posedge clk);
   endtask : xfer
   // chip select held low long enough to wake the device
   task automatic wake_pulse();
      cs_n <= 1'b0;
      repeat (200) @(posedge clk);
      cs_n <= 1'b1;
   endtask : wake_pulse
   // one pulse per run, so the spacing limit is never at stake
   task automatic pulse_sync();
      sync_clock_input <= 1'b1;
      repeat (50) @(posedge clk);
      sync_clock_input <= 1'b0;
   endtask : pulse_sync
endmodule : host_master_model

/* File: testbench/inertial_sensor_timing_ctrl_tb.sv */
// self-checking bench for the timing controller
// assumes shortened start and tick counts set at the instance
`timescale 1ns/1ps
module inertial_sensor_timing_ctrl_tb;
   import imu_timing_pkg::*;
   localparam int TK = 20;
   typedef struct packed {logic [7:0] s; logic lp;} mode_row_t;
   typedef struct packed {logic [7:0] s; logic fl; int tk;} wait_row_t;
   mode_row_t rows [6] = '{'{8'h00, 1'b0}, '{8'h01, 1'b0},
      '{8'h09, 1'b0}, '{8'h0A, 1'b1}, '{8'h0B, 1'b1}, '{8'hFF, 1'b1}};
   wait_row_t waits [4] = '{'{8'h08, 1'b0, SLEEP_NORM_TK},
      '{8'h0A, 1'b0, SLEEP_LP_TK}, '{8'h09, 1'b1, FLASH_NORM_TK},
      '{8'hFF, 1'b1, FLASH_LP_TK}};
   logic clk, rst, ext_sync_en, sleep_req, flash_test_req;
   logic [7:0] sample_period_setting;
   logic [15:0] sensor_data, rx;
   logic sclk, cs_n, mosi, sync_clock_input;
   logic miso, data_ready_pin, low_power_mode, busy;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int n, dr;
   inertial_sensor_timing_ctrl #(.START_NORM_TICKS(2),
      .START_LP_TICKS(3), .TICK_CYCLES(TK)) uut (.clk(clk), .rst(rst),
      .sample_period_setting(sample_period_setting),
      .ext_sync_en(ext_sync_en), .sync_clock_input(sync_clock_input),
      .sleep_req(sleep_req), .flash_test_req(flash_test_req),
      .sensor_data(sensor_data), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .data_ready_pin(data_ready_pin),
      .low_power_mode(low_power_mode), .busy(busy));
   host_master_model host (.clk(clk), .miso(miso), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .sync_clock_input(sync_clock_input));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // compares and closing
   // ----------------------------------------
   task automatic fail(input string m);
      num_errors++;
      $display("Error at %0t: %s", $time, m);
   endtask : fail
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) fail("flag mismatch");
   endtask : chk_bit
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) fail("read data mismatch");
   endtask : chk_word
   task automatic chk_span(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) fail("cycle count out of range");
   endtask : chk_span
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail("timeout");
         give_verdict();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // counts cycles until busy drops and drdy cycles seen meanwhile
   task automatic busy_span(output int k, output int d);
      k = 0;
      d = 0;
      while (busy !== 1'b0 && k < 3000) begin
         @(posedge clk);
         #1 k++;
         if (data_ready_pin !== 1'b0) d++;
      end
   endtask : busy_span
   task automatic wait_rise(output int k);
      logic p;
      k = 0;
      p = data_ready_pin;
      while (!(p === 1'b0 && data_ready_pin === 1'b1) && k < 9000) begin
         p = data_ready_pin;
         @(posedge clk);
         #1 k++;
      end
   endtask : wait_rise
   task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
      host.xfer({1'b0, a, 8'h00}, low_power_mode, d);
      host.xfer(16'h0000, low_power_mode, d);
   endtask : read_reg
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      sample_period_setting = 8'h01;
      ext_sync_en = 1'b0;
      sleep_req = 1'b0;
      flash_test_req = 1'b0;
      sensor_data = 16'hA5C3;
      repeat (20) @(posedge clk);
      #1 chk_bit(busy, 1'b1);
      chk_bit(data_ready_pin, 1'b0);
      @(posedge clk) rst <= 1'b0;
      #1 busy_span(n, dr);
      chk_span(n, 2 * TK - 3, 2 * TK + 6);
      foreach (rows[i]) begin
         @(posedge clk) sample_period_setting <= rows[i].s;
         repeat (3) @(posedge clk);
         #1 chk_bit(low_power_mode, rows[i].lp);
      end
      foreach (rows[i]) if (i == 1 || i == 5) begin
         @(posedge clk) sample_period_setting <= (i == 1) ? 8'h08 : 8'hFF;
         #1 wait_rise(n);
         wait_rise(n);
         chk_span(n, TK * ((i == 1) ? 8 : 255) - 1,
            TK * ((i == 1) ? 8 : 255) + 1);
      end
      @(posedge clk) sample_period_setting <= 8'h01;
      ext_sync_en <= 1'b1;
      repeat (200) @(posedge clk);
      host.pulse_sync();
      #1 wait_rise(n);
      chk_span(n + 50, 5995, 6015);
      repeat (99) @(posedge clk);
      #1 chk_bit(data_ready_pin, 1'b1);
      @(posedge clk);
      #1 chk_bit(data_ready_pin, 1'b0);
      @(posedge clk) sensor_data <= 16'h0000;
      read_reg(7'h04, rx);
      chk_word(rx, 16'hA5C3);
      read_reg(7'h05, rx);
      chk_word(rx, 16'h00A5);
      @(posedge clk) ext_sync_en <= 1'b0;
      foreach (waits[i]) begin
         // align to a sample tick so the wait length is exact
         @(posedge clk) sample_period_setting <= waits[i].s;
         #1 wait_rise(n);
         @(posedge clk) sleep_req <= !waits[i].fl;
         flash_test_req <= waits[i].fl;
         @(posedge clk) flash_test_req <= 1'b0;
         repeat (9) @(posedge clk);
         #1 chk_bit(busy, 1'b1);
         @(posedge clk) sleep_req <= 1'b0;
         #1 busy_span(n, dr);
         chk_span(n, waits[i].tk * TK - 12, waits[i].tk * TK + 6);
         chk_span(dr, 0, 0);
      end
      // wake by chip select alone: sleep request still high at the cs fall
      @(posedge clk) sample_period_setting <= 8'h08;
      #1 wait_rise(n);
      @(posedge clk) sleep_req <= 1'b1;
      fork
         host.wake_pulse();
         begin
            repeat (4) @(posedge clk);
            sleep_req <= 1'b0;
            #1 busy_span(n, dr);
         end
      join
      chk_span(n, SLEEP_NORM_TK * TK - 5, SLEEP_NORM_TK * TK - 5);
      chk_span(dr, 0, 0);
      @(posedge clk) sample_period_setting <= 8'h0A;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1 busy_span(n, dr);
      chk_span(n, 3 * TK - 3, 3 * TK + 6);
      give_verdict();
   end
endmodule : inertial_sensor_timing_ctrl_tb
